/* File: verilog/vector_compare_average_unit.sv */
// Packed-vector execute stage for half-word average and lane compares
`include "vcau_map.svh"

module vector_compare_average_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction and operands from decode
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire vcau_pkg::vec_t first_source_register,
  input wire vcau_pkg::vec_t second_source_register,
  // Result towards the register file
  output logic result_valid,
  output logic result_write,
  output logic [4:0] result_dest,
  output vcau_pkg::vec_t result_data,
  output logic instr_rejected
);
  import vcau_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // Primary opcode matches the vector group
  logic primary_hit;
  // Secondary opcode field
  logic [7:0] secondary;
  // Decoded kind and lane width
  op_kind_t next_kind;
  logic next_byte;
  // Combined lane results
  vec_t next_data;

  // Secondary opcode to operation kind
  function automatic op_kind_t decode_kind(input logic [7:0] sec);
    case (sec)
      `VCAU_SEC_AVG_H: decode_kind = kind_avg;
      `VCAU_SEC_EQ_B, `VCAU_SEC_EQ_H: decode_kind = kind_eq;
      `VCAU_SEC_GE_B, `VCAU_SEC_GE_H: decode_kind = kind_ge;
      `VCAU_SEC_GT_B, `VCAU_SEC_GT_H: decode_kind = kind_gt;
      `VCAU_SEC_LE_B, `VCAU_SEC_LE_H: decode_kind = kind_le;
      `VCAU_SEC_LT_B: decode_kind = kind_lt;
      default: decode_kind = kind_none;
    endcase
  endfunction

  // Byte-lane forms are the even compare codes
  function automatic logic is_byte_form(input logic [7:0] sec);
    is_byte_form = (sec == `VCAU_SEC_EQ_B) || (sec == `VCAU_SEC_GE_B) ||
                   (sec == `VCAU_SEC_GT_B) || (sec == `VCAU_SEC_LE_B) ||
                   (sec == `VCAU_SEC_LT_B);
  endfunction

  // Field extraction; reserved bits are not checked
  assign primary_hit =
    (instr_word[`VCAU_PRIMARY_MSB:`VCAU_PRIMARY_LSB] == `VCAU_PRIMARY_OPCODE);
  assign secondary = instr_word[`VCAU_SECONDARY_MSB:`VCAU_SECONDARY_LSB];

  // Kind is none outside the vector group
  always_comb begin
    next_kind = primary_hit ? decode_kind(secondary) : kind_none;
    next_byte = is_byte_form(secondary);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lane datapath

  // Four 16-bit slices cover the 64-bit operands
  generate
    for (genvar s = 0; s < 4; s++) begin : g_slice
      lane_slice u_slice (
        .lane_a(first_source_register[16*s +: 16]),
        .lane_b(second_source_register[16*s +: 16]),
        .kind(next_kind),
        .byte_lanes(next_byte),
        .lane_res(next_data[16*s +: 16])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Result stage

  // Valid strobe follows every offered instruction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_valid <= 1'b0;
    end else begin
      result_valid <= instr_valid;
    end
  end

  // Write enable for supported, refusal for anything else
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_write <= 1'b0;
      instr_rejected <= 1'b0;
    end else begin
      // Only decoded operations write
      result_write <= instr_valid && (next_kind != kind_none);
      instr_rejected <= instr_valid && (next_kind == kind_none);
    end
  end

  // Destination index and data held until the next write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_dest <= `VCAU_DEST_RESET;
      result_data <= `VCAU_RESULT_RESET;
    end else if (instr_valid && (next_kind != kind_none)) begin
      // Destination field
      result_dest <= instr_word[`VCAU_DEST_MSB:`VCAU_DEST_LSB];
      // Lane results
      result_data <= next_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Previous-cycle inputs for checking
  logic [31:0] prev_word;
  vec_t prev_a;
  vec_t prev_b;
  logic [7:0] prev_sec;
  logic [16:0] prev_sum0;

  // Capture the previous cycle's instruction word and operands, offered or not
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_word <= 32'h0000_0000;
      prev_a <= 64'h0000_0000_0000_0000;
      prev_b <= 64'h0000_0000_0000_0000;
    end else begin
      prev_word <= instr_word;
      prev_a <= first_source_register;
      prev_b <= second_source_register;
    end
  end

  assign prev_sec = prev_word[`VCAU_SECONDARY_MSB:`VCAU_SECONDARY_LSB];
  assign prev_sum0 = {1'b0, prev_a[15:0]} + {1'b0, prev_b[15:0]};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // A vector instruction with the given secondary code
  sequence vec_issue(logic [7:0] code);
    instr_valid && primary_hit && (secondary == code);
  endsequence

  // Written result of the given secondary code
  sequence vec_done(logic [7:0] code);
    result_write && (prev_sec == code);
  endsequence

  avg_half_lane_a: assert property (
    vec_issue(`VCAU_SEC_AVG_H) |=>
      result_data[15:0] == prev_sum0[16:1] && result_write)
    else $error("half-word average lane 0 wrong");

  decode_reject_a: assert property (
    instr_valid && !primary_hit |=> instr_rejected && !result_write)
    else $error("foreign primary opcode was not refused");

  dest_field_a: assert property (
    result_write |->
      result_dest == prev_word[`VCAU_DEST_MSB:`VCAU_DEST_LSB] &&
      prev_word[`VCAU_PRIMARY_MSB:`VCAU_PRIMARY_LSB] ==
        `VCAU_PRIMARY_OPCODE &&
      decode_kind(prev_sec) != kind_none)
    else $error("destination or decode mismatch");

  // A refused instruction leaves destination and data untouched
  reject_hold_a: assert property (
    instr_rejected |-> $stable(result_data) && $stable(result_dest))
    else $error("refused instruction changed the result");

  eq_byte_lane_a: assert property (
    vec_done(`VCAU_SEC_EQ_B) |->
      result_data[47:40] == {8{prev_a[47:40] == prev_b[47:40]}})
    else $error("byte equal lane 5 wrong");

  ge_half_lane_a: assert property (
    vec_done(`VCAU_SEC_GE_H) |->
      result_data[63:48] == {16{prev_a[63:48] >= prev_b[63:48]}})
    else $error("half-word at-least lane 3 wrong");

  gt_byte_lane_a: assert property (
    vec_issue(`VCAU_SEC_GT_B) ##1 vec_done(`VCAU_SEC_GT_B) |->
      result_data[7:0] == {8{prev_a[7:0] > prev_b[7:0]}})
    else $error("byte above lane 0 wrong");

  le_half_lane_a: assert property (
    vec_done(`VCAU_SEC_LE_H) |->
      result_data[31:16] == {16{prev_a[31:16] <= prev_b[31:16]}})
    else $error("half-word at-most lane 1 wrong");

  byte_fill_a: assert property (
    result_write && is_byte_form(prev_sec) |->
      (result_data[15:8] == 8'h00 || result_data[15:8] == 8'hff) &&
      (result_data[55:48] == 8'h00 || result_data[55:48] == 8'hff))
    else $error("byte compare lane not filled");

  lt_byte_lane_a: assert property (
    vec_done(`VCAU_SEC_LT_B) |->
      result_data[23:16] == {8{prev_a[23:16] < prev_b[23:16]}})
    else $error("byte below lane 2 wrong");

  avg_carry_a: assert property (
    vec_issue(`VCAU_SEC_AVG_H) and
      (first_source_register[47:32] == 16'hffff &&
       second_source_register[47:32] == 16'hffff) |=>
      result_data[47:32] == 16'hffff)
    else $error("average lost its carry");

endmodule

/* File: pkg/vcau_map.svh */
// Opcode values, field positions and reset values of the compare/average unit
`ifndef VCAU_MAP_SVH
`define VCAU_MAP_SVH

// Primary opcode of every vector instruction
`define VCAU_PRIMARY_OPCODE 6'h0a
// Instruction word field positions
`define VCAU_PRIMARY_MSB 31
`define VCAU_PRIMARY_LSB 26
`define VCAU_DEST_MSB 25
`define VCAU_DEST_LSB 21
`define VCAU_SRC1_MSB 20
`define VCAU_SRC1_LSB 16
`define VCAU_SRC2_MSB 15
`define VCAU_SRC2_LSB 11
`define VCAU_RSVD_MSB 10
`define VCAU_RSVD_LSB 8
`define VCAU_SECONDARY_MSB 7
`define VCAU_SECONDARY_LSB 0
// Secondary opcodes
`define VCAU_SEC_AVG_H 8'h3a
`define VCAU_SEC_EQ_B 8'h40
`define VCAU_SEC_EQ_H 8'h41
`define VCAU_SEC_GE_B 8'h42
`define VCAU_SEC_GE_H 8'h43
`define VCAU_SEC_GT_B 8'h44
`define VCAU_SEC_GT_H 8'h45
`define VCAU_SEC_LE_B 8'h46
`define VCAU_SEC_LE_H 8'h47
`define VCAU_SEC_LT_B 8'h48
// Reset values of the result stage
`define VCAU_RESULT_RESET 64'h0000_0000_0000_0000
`define VCAU_DEST_RESET 5'h00
// Cycles from instruction taken to result shown
`define VCAU_LATENCY 1

`endif

/* File: pkg/vcau_pkg.sv */
// Types shared by the compare/average unit and its lane slices
package vcau_pkg;

  // Operation kind after decode
  typedef enum logic [2:0] {
    kind_none = 3'h0,
    kind_avg = 3'h1,
    kind_eq = 3'h2,
    kind_ge = 3'h3,
    kind_gt = 3'h4,
    kind_le = 3'h5,
    kind_lt = 3'h6
  } op_kind_t;

  // One packed 64-bit vector operand
  typedef logic [63:0] vec_t;

endpackage

/* File: verilog/lane_slice.sv */
// One 16-bit slice: half-word average, or byte / half-word lane compares
module lane_slice (
  // Operand slices
  input wire logic [15:0] lane_a,
  input wire logic [15:0] lane_b,
  // Operation select
  input wire vcau_pkg::op_kind_t kind,
  input wire logic byte_lanes,
  // Slice result
  output logic [15:0] lane_res
);
  import vcau_pkg::*;

  // Sum with one spare carry bit
  logic [16:0] half_sum;

  // Unsigned lane test for the selected compare kind
  function automatic logic lane_test(input op_kind_t k,
                                     input logic [15:0] a,
                                     input logic [15:0] b);
    case (k)
      kind_eq: lane_test = (a == b);
      kind_ge: lane_test = (a >= b);
      kind_gt: lane_test = (a > b);
      kind_le: lane_test = (a <= b);
      kind_lt: lane_test = (a < b);
      default: lane_test = 1'b0;
    endcase
  endfunction

  // Carry kept so the halved sum never overflows
  assign half_sum = {1'b0, lane_a} + {1'b0, lane_b};

  // Pick average or replicated compare mask
  always_comb begin
    if (kind == kind_avg) begin
      // Sum shifted right by one
      lane_res = half_sum[16:1];
    end else if (byte_lanes) begin
      // Two byte lanes, each flag filling its byte
      lane_res = {{8{lane_test(kind, {8'h00, lane_a[15:8]},
                               {8'h00, lane_b[15:8]})}},
                  {8{lane_test(kind, {8'h00, lane_a[7:0]},
                               {8'h00, lane_b[7:0]})}}};
    end else begin
      // One half-word lane
      lane_res = {16{lane_test(kind, lane_a, lane_b)}};
    end
  end

endmodule

/* File: test/gpr_file_model.sv */
// Register file model that feeds operands and takes write-backs
module gpr_file_model (
  // Clock
  input wire logic clk,
  // Instruction offered by decode
  input wire logic [31:0] instr_word,
  // Write-back from the unit
  input wire logic result_write,
  input wire logic [4:0] result_dest,
  input wire vcau_pkg::vec_t result_data,
  // Operand values to the unit
  output vcau_pkg::vec_t src_a,
  output vcau_pkg::vec_t src_b
);
  timeunit 1ns;
  timeprecision 1ns;
  import vcau_pkg::*;

  vec_t regs [32]; // Register contents, loaded by the bench

  // Operands follow the source fields in the same cycle
  assign src_a = regs[instr_word[20:16]];
  assign src_b = regs[instr_word[15:11]];

  // Write-back only when the unit marks a result as written
  always @(posedge clk) begin
    if (result_write) begin
      regs[result_dest] <= result_data;
    end
  end
endmodule

/* File: test/vector_compare_average_unit_test.sv */
// Self-checking bench for the compare/average unit
module vector_compare_average_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  import vcau_pkg::*;

  ////////////////////////////////////////
  logic clk = 1'b0; // Core clock
  logic rst = 1'b1; // Reset, held at start
  logic instr_valid = 1'b0; // Instruction strobe
  logic [31:0] instr_word = 32'h0000_0000; // Instruction
  vec_t src_a, src_b, result_data; // Operands and result
  logic result_valid, result_write, instr_rejected; // Result pulses
  logic [4:0] result_dest; // Destination index
  int err_count = 0; // Mismatches
  int n_checks = 0; // Comparisons made
  // Lanes chosen to give equal, above and below in both widths
  localparam vec_t opa = 64'h8000_ffff_1234_0001;
  localparam vec_t opb = 64'h7fff_ffff_1235_0000;
  // Every supported secondary code
  logic [7:0] codes [10] = '{8'h3a, 8'h40, 8'h41, 8'h42, 8'h43,
                             8'h44, 8'h45, 8'h46, 8'h47, 8'h48};

  // Clock at 25 MHz
  always #20 clk = ~clk;

  vector_compare_average_unit dut (.clk(clk), .rst(rst),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .first_source_register(src_a), .second_source_register(src_b),
    .result_valid(result_valid), .result_write(result_write),
    .result_dest(result_dest), .result_data(result_data),
    .instr_rejected(instr_rejected));

  gpr_file_model rf (.clk(clk), .instr_word(instr_word),
    .result_write(result_write), .result_dest(result_dest),
    .result_data(result_data), .src_a(src_a), .src_b(src_b));

  ////////////////////////////////////////
  // Instruction word; destination taken from the code's low bits
  function automatic logic [31:0] wd(logic [5:0] p, logic [2:0] rsv,
                                     logic sw, logic [7:0] sec);
    return {p, 2'b11, sec[2:0], sw ? 5'h02 : 5'h01,
            sw ? 5'h01 : 5'h02, rsv, sec};
  endfunction

  // Lane-by-lane expected result, unsigned compares
  function automatic vec_t expect_of(logic [7:0] sec, vec_t a, vec_t b);
    vec_t r;
    logic [16:0] s;
    logic f;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      case (sec)
        8'h40, 8'h41: f = a[8*i+:8] == b[8*i+:8];
        8'h42, 8'h43: f = a[8*i+:8] >= b[8*i+:8];
        8'h44, 8'h45: f = a[8*i+:8] > b[8*i+:8];
        8'h46, 8'h47: f = a[8*i+:8] <= b[8*i+:8];
        default: f = a[8*i+:8] < b[8*i+:8];
      endcase
      r[8*i+:8] = {8{f}};
    end
    // Half-word forms overwrite with four wide lanes
    for (int i = 0; i < 4; i++) begin
      s = {1'b0, a[16*i+:16]} + {1'b0, b[16*i+:16]};
      case (sec)
        8'h41: f = a[16*i+:16] == b[16*i+:16];
        8'h43: f = a[16*i+:16] >= b[16*i+:16];
        8'h45: f = a[16*i+:16] > b[16*i+:16];
        8'h47: f = a[16*i+:16] <= b[16*i+:16];
        default: f = 1'b0;
      endcase
      if (sec == 8'h3a) begin
        r[16*i+:16] = s[16:1];
      end else if (sec[0]) begin
        r[16*i+:16] = {16{f}};
      end
    end
    return r;
  endfunction

  // One comparison
  task automatic chk(string nm, logic [63:0] got, logic [63:0] ex);
    n_checks++;
    if (got !== ex) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // One instruction, its one-cycle answer, then the held state
  task automatic run_one(string nm, logic [31:0] w, logic ok);
    vec_t ex;
    logic [4:0] dx;
    ex = ok ? expect_of(w[7:0], rf.regs[w[20:16]], rf.regs[w[15:11]])
            : result_data;
    dx = ok ? w[25:21] : result_dest;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    chk({nm, " flags"}, 64'({result_valid, result_write, instr_rejected}),
        64'({1'b1, ok, !ok}));
    chk({nm, " data"}, result_data, ex);
    chk({nm, " dest"}, 64'(result_dest), 64'(dx));
    @(posedge clk);
    #1;
    chk({nm, " drop"}, 64'({result_valid, result_write, instr_rejected}),
        64'h0);
    chk({nm, " hold"}, result_data, ex);
  endtask

  // Two instructions on consecutive cycles
  task automatic back_to_back(logic [31:0] w1, logic [31:0] w2);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= w1;
    @(posedge clk);
    instr_word <= w2;
    #1;
    chk("first data", result_data, expect_of(w1[7:0], opa, opb));
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    chk("second flags", 64'({result_valid, result_write}), 64'h3);
    chk("second data", result_data,
        expect_of(w2[7:0], opa, opb));
    chk("second dest", 64'(result_dest), 64'(w2[25:21]));
  endtask

  // Closing report and verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    rf.regs[1] = opa;
    rf.regs[2] = opb;
    @(posedge clk);
    #1;
    chk("reset flags", 64'({result_valid, result_write, instr_rejected}),
        64'h0);
    chk("reset data", result_data, 64'h0);
    chk("reset dest", 64'(result_dest), 64'h0);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Every code once, operand order alternating, reserved bits varied
    for (int i = 0; i < 10; i++) begin
      run_one($sformatf("code %h", codes[i]),
              wd(6'h0a, 3'(i), i[0], codes[i]),
              1'b1);
    end
    run_one("bad primary", wd(6'h0b, 3'h0, 1'b0, 8'h40), 1'b0);
    run_one("bad secondary", wd(6'h0a, 3'h0, 1'b0, 8'h49), 1'b0);
    back_to_back(wd(6'h0a, 3'h7, 1'b0, 8'h48),
                 wd(6'h0a, 3'h0, 1'b0, 8'h3a));
    wrap_up();
  end

  // Watchdog: tests need under 100 cycles, allow 500
  initial begin
    #20000;
    err_count++;
    wrap_up();
  end
endmodule
